//--- dma_pkg.sv
// Purpose: shared constants and types of the descriptor dma channel
// Assumes: one clock pclk at 20 MHz, asynchronous active-low reset
// Notes:   used by dma_channel_engine, dma_fabric_port and dma_link_monitor
//
// Overview of operation
// - notify by interrupt line or 32-bit wakeup write
// - active context state hidden from software
// - 3-bit port select; streams 0 data, 1 control
// - device register transfers drive register address sequence
// - control write restarts an idle channel
// - busy-retry repeats same bus access until done
// - unrecoverable bus error sets channel dead flag
// - software clears run then sets it to recover
// - status returned by stream or register-range transfers
// - branch, interrupt, stall fields steer descriptor sequencing
// - descriptor holds opcode, count, address, dependent word
// - word 3 field positions for opcode, port, controls
// - completion writes status and residual into word 0
// - opcode decode, codes 8 to 15 reserved
// - port select decode of streams and spaces
// - port select picks stream or immediate address space
// - stream port with immediate load/store is illegal; not checked here, such an access goes to the device port
// - every defined operation is implemented
// - pointer advances 16, jumps, or holds on stop
// - condition is masked status equal masked value
// - two-bit branch control decode
// - two-bit interrupt control decode

package dma_pkg;
  // ----------------------------------------------------------------
  // descriptor layout
  // ----------------------------------------------------------------
  localparam int W3_CMD_LSB = 28;
  localparam int W3_KEY_LSB = 24;
  localparam int W3_INT_LSB = 20;
  localparam int W3_BR_LSB  = 18;
  localparam int W3_WT_LSB  = 16;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [15:0] WORD_CNT   = 16'h0004;
  localparam logic [1:0]  LAST_WORD  = 2'h3;

  // ----------------------------------------------------------------
  // opcodes, port selects, condition controls
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_OUT_MORE = 4'h0;
  localparam logic [3:0] CMD_OUT_LAST = 4'h1;
  localparam logic [3:0] CMD_IN_MORE  = 4'h2;
  localparam logic [3:0] CMD_IN_LAST  = 4'h3;
  localparam logic [3:0] CMD_STORE_Q  = 4'h4;
  localparam logic [3:0] CMD_LOAD_Q   = 4'h5;
  localparam logic [3:0] CMD_NO_OP    = 4'h6;
  localparam logic [3:0] CMD_STOP     = 4'h7;
  localparam logic [2:0] PORT_DATA_STREAM    = 3'h0;
  localparam logic [2:0] PORT_CONTROL_STREAM = 3'h1;
  localparam logic [2:0] PORT_CHAN_REGS      = 3'h5;
  localparam logic [2:0] PORT_SYSTEM         = 3'h6;
  localparam logic [2:0] PORT_DEVICE         = 3'h7;
  localparam logic [1:0] CTL_NEVER  = 2'h0;
  localparam logic [1:0] CTL_SET    = 2'h1;
  localparam logic [1:0] CTL_CLEAR  = 2'h2;
  localparam logic [1:0] CTL_ALWAYS = 2'h3;

  // ----------------------------------------------------------------
  // channel registers and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_PTR       = 8'h08;
  localparam logic [7:0] REG_JSEL      = 8'h0c;
  localparam logic [7:0] REG_NSEL      = 8'h10;
  localparam logic [7:0] REG_SSEL      = 8'h14;
  localparam logic [7:0] REG_WAKE_ADDR = 8'h18;
  localparam int CTL_RUN    = 15;
  localparam int CTL_WMODE  = 13;
  localparam int CTL_WAKE   = 12;
  localparam int STAT_RUN    = 15;
  localparam int STAT_DEAD   = 11;
  localparam int STAT_ACTIVE = 10;
  localparam int SEL_MASK_LSB = 16;
  localparam int SEL_VAL_LSB  = 0;

  // link address spaces
  localparam logic SP_MEM  = 1'b0;
  localparam logic SP_PORT = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_SRC, ST_DST, ST_STALL, ST_WBACK, ST_NOTIFY, ST_NEXT
  } chan_state_t;
endpackage : dma_pkg

//--- dma_link_if.sv
// Purpose: link between the channel engine and the bus/port fabric
// Assumes: both ends on pclk; acc_req held until ack or err, or until run is cleared
// Notes:   responses are one-cycle pulses
`timescale 1ns/100ps
interface dma_link_if;
  logic        acc_req;
  logic        acc_we;
  logic        acc_space;
  logic [2:0]  acc_key;
  logic [31:0] acc_addr;
  logic [31:0] acc_wdata;
  logic        acc_ack;
  logic        acc_retry;
  logic        acc_err;
  logic [31:0] acc_rdata;
  logic        notify_irq;

  modport engine (
    output acc_req, acc_we, acc_space, acc_key, acc_addr, acc_wdata,
    output notify_irq,
    input  acc_ack, acc_retry, acc_err, acc_rdata
  );
  modport fabric (
    input  acc_req, acc_we, acc_space, acc_key, acc_addr, acc_wdata,
    input  notify_irq,
    output acc_ack, acc_retry, acc_err, acc_rdata
  );
endinterface : dma_link_if

//--- dma_fabric_port.sv
// Purpose: far end of the link: system bus and device port adapter
// Assumes: bus and port responders answer while their request is high
// Notes:   one access in flight; a retried access is re-sent as new
`timescale 1ns/100ps
module dma_fabric_port
  import dma_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link
  dma_link_if.fabric       link,
  // system bus side
  output logic             bus_req,
  output logic             bus_we,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_wdata,
  input  wire logic        bus_done,
  input  wire logic        bus_retry,
  input  wire logic        bus_fault,
  input  wire logic [31:0] bus_rdata,
  // device port side
  output logic             dp_req,
  output logic             dp_we,
  output logic [2:0]       dp_key,
  output logic [31:0]      dp_addr,
  output logic [31:0]      dp_wdata,
  input  wire logic        dp_done,
  input  wire logic [31:0] dp_rdata,
  // processor interrupt line
  output logic             irq_line
);
  typedef struct packed {
    logic        breq;
    logic        dreq;
    logic        we;
    logic [2:0]  key;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        ack;
    logic        retry;
    logic        err;
    logic [31:0] rdata;
    logic        irq;
  } fab_t;

  fab_t q, n;

  // ----------------------------------------------------------------
  // accept, forward, answer
  // ----------------------------------------------------------------
  always_comb begin
    n       = q;
    n.ack   = 1'b0;
    n.retry = 1'b0;
    n.err   = 1'b0;
    n.irq   = link.notify_irq;
    // a pulse still on the link means the request seen is the old one
    if (!q.breq && !q.dreq && link.acc_req && !(q.ack || q.retry || q.err)) begin
      n.we    = link.acc_we;
      n.key   = link.acc_key;
      n.addr  = link.acc_addr;
      n.wdata = link.acc_wdata;
      n.breq  = (link.acc_space == SP_MEM);
      n.dreq  = (link.acc_space == SP_PORT);
    end
    if (q.breq && (bus_done || bus_retry || bus_fault)) begin
      n.breq  = 1'b0;
      n.ack   = bus_done;
      n.retry = bus_retry && !bus_done;
      n.err   = bus_fault && !bus_done && !bus_retry;
      n.rdata = bus_rdata;
    end
    if (q.dreq && dp_done) begin
      n.dreq  = 1'b0;
      n.ack   = 1'b1;
      n.rdata = dp_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign bus_req        = q.breq;
  assign bus_we         = q.we;
  assign bus_addr       = q.addr;
  assign bus_wdata      = q.wdata;
  assign dp_req         = q.dreq;
  assign dp_we          = q.we;
  assign dp_key         = q.key;
  assign dp_addr        = q.addr;
  assign dp_wdata       = q.wdata;
  assign irq_line       = q.irq;
  assign link.acc_ack   = q.ack;
  assign link.acc_retry = q.retry;
  assign link.acc_err   = q.err;
  assign link.acc_rdata = q.rdata;
endmodule : dma_fabric_port

//--- dma_channel_engine.sv
// Purpose: descriptor fetch, decode and execute for one channel
// Assumes: apb slave for software, link to bus/port fabric
// Notes:   transfers move whole 32-bit words; residual saturates at 0
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
module dma_channel_engine
  import dma_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  dma_link_if.engine       link
);
  typedef struct packed {
    chan_state_t st;
    logic        run;
    logic        dead;
    logic        wmode;
    logic        wake;
    logic [7:0]  s;
    logic [31:0] ptr;
    logic [31:0] jsel;
    logic [31:0] nsel;
    logic [31:0] ssel;
    logic [31:0] wake_addr;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [1:0]  widx;
    logic [31:0] maddr;
    logic [31:0] paddr;
    logic [15:0] beats;
    logic [15:0] resid;
    logic [31:0] data;
    logic        req;
    logic        we;
    logic        sp;
    logic [2:0]  key;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        irq;
    logic [31:0] prdata;
  } eng_t;

  eng_t q, n;

  logic [3:0]  opc;
  logic [2:0]  key;
  logic        from_b;
  logic        b_sp;
  logic        t_go;
  logic        t_int;
  logic        t_sp;
  logic        t_we;
  logic [31:0] t_addr;
  logic [31:0] t_wdata;
  logic        done;
  logic [31:0] rdat;
  logic [16:0] nwords;
  logic        wr_acc;
  logic        hit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic decide(input logic [1:0] f, input logic c);
    unique case (f)
      CTL_NEVER:  decide = 1'b0;
      CTL_SET:    decide = c;
      CTL_CLEAR:  decide = !c;
      CTL_ALWAYS: decide = 1'b1;
    endcase
  endfunction : decide

  function automatic logic cond(input logic [7:0] s, input logic [31:0] sel);
    cond = ((s & sel[SEL_MASK_LSB +: 8])
           == (sel[SEL_VAL_LSB +: 8] & sel[SEL_MASK_LSB +: 8]));
  endfunction : cond

  function automatic logic [15:0] stat_word(input eng_t r);
    stat_word              = '0;
    stat_word[STAT_RUN]    = r.run;
    stat_word[STAT_DEAD]   = r.dead;
    stat_word[STAT_ACTIVE] = (r.st != ST_IDLE);
    stat_word[7:0]         = r.s;
  endfunction : stat_word

  // the context state itself has no address here on purpose
  function automatic logic [31:0] rd_reg(input eng_t r, input logic [7:0] a);
    unique case (a)
      REG_CTRL:      rd_reg = {16'h0, r.run, 1'b0, r.wmode, 5'h0, r.s};
      REG_STATUS:    rd_reg = {16'h0, stat_word(r)};
      REG_PTR:       rd_reg = r.ptr;
      REG_JSEL:      rd_reg = r.jsel;
      REG_NSEL:      rd_reg = r.nsel;
      REG_SSEL:      rd_reg = r.ssel;
      REG_WAKE_ADDR: rd_reg = r.wake_addr;
      default:       rd_reg = 32'h0000_0000;
    endcase
  endfunction : rd_reg

  assign opc    = q.w3[W3_CMD_LSB +: 4];
  assign key    = q.w3[W3_KEY_LSB +: 3];
  assign from_b = (opc == CMD_IN_MORE) || (opc == CMD_IN_LAST)
               || (opc == CMD_LOAD_Q);
  assign b_sp   = (key == PORT_SYSTEM) ? SP_MEM : SP_PORT;
  // count comes from the word arriving now, not the previous descriptor
  assign nwords = {1'b0, link.acc_rdata[15:0]} + {15'h0, LAST_WORD};
  assign hit    = (paddr[1:0] == 2'h0) && (paddr <= REG_WAKE_ADDR);
  assign wr_acc = psel && penable && pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n       = q;
    n.irq   = 1'b0;
    t_go    = 1'b0;
    t_int   = 1'b0;
    t_sp    = SP_MEM;
    t_we    = 1'b0;
    t_addr  = q.ptr;
    t_wdata = q.data;
    done    = 1'b0;
    rdat    = link.acc_rdata;

    if (psel && !penable) begin
      n.prdata = rd_reg(q, paddr);
    end
    if (wr_acc && paddr == REG_CTRL) begin
      n.run   = pwdata[CTL_RUN];
      n.wmode = pwdata[CTL_WMODE];
      n.s     = pwdata[7:0];
      n.wake  = pwdata[CTL_WAKE];
      if (!pwdata[CTL_RUN]) begin
        n.dead = 1'b0;
      end
    end
    if (wr_acc && paddr == REG_PTR && q.st == ST_IDLE) begin
      n.ptr = pwdata;
    end
    if (wr_acc && paddr == REG_JSEL) n.jsel = pwdata;
    if (wr_acc && paddr == REG_NSEL) n.nsel = pwdata;
    if (wr_acc && paddr == REG_SSEL) n.ssel = pwdata;
    if (wr_acc && paddr == REG_WAKE_ADDR) n.wake_addr = pwdata;

    // what the current step accesses
    unique case (q.st)
      ST_FETCH: begin
        t_go   = 1'b1;
        t_addr = q.ptr + {28'h0, q.widx, 2'h0};
      end
      ST_SRC: begin
        t_go = 1'b1;
        if (opc == CMD_STORE_Q) begin
          t_int = 1'b1;
        end else if (from_b) begin
          t_sp   = b_sp;
          t_int  = (key == PORT_CHAN_REGS);
          t_addr = q.paddr;
        end else begin
          t_addr = q.maddr;
        end
      end
      ST_DST: begin
        t_go = 1'b1;
        t_we = 1'b1;
        if (from_b) begin
          t_addr = q.maddr;
        end else begin
          t_sp   = b_sp;
          t_int  = (key == PORT_CHAN_REGS);
          t_addr = q.paddr;
        end
      end
      ST_WBACK: begin
        t_go    = 1'b1;
        t_we    = 1'b1;
        t_wdata = {stat_word(q), q.resid};
      end
      ST_NOTIFY: begin
        t_go    = q.wmode && decide(q.w3[W3_INT_LSB +: 2], cond(q.s, q.nsel));
        t_we    = 1'b1;
        t_addr  = q.wake_addr;
        t_wdata = q.ptr;
      end
      ST_IDLE, ST_STALL, ST_NEXT: ;
    endcase

    // one access: internal, or over the link
    if (t_go && t_int) begin
      done = 1'b1;
      rdat = (q.st == ST_SRC && opc == CMD_STORE_Q) ? q.w1 : rd_reg(q, t_addr[7:0]);
      if (t_we && t_addr[7:0] == REG_JSEL) n.jsel = t_wdata;
      if (t_we && t_addr[7:0] == REG_NSEL) n.nsel = t_wdata;
      if (t_we && t_addr[7:0] == REG_SSEL) n.ssel = t_wdata;
    end else if (t_go && !q.req) begin
      n.req   = 1'b1;
      n.we    = t_we;
      n.sp    = t_sp;
      n.key   = key;
      n.addr  = t_addr;
      n.wdata = t_wdata;
    end else if (t_go && link.acc_ack) begin
      n.req = 1'b0;
      done  = 1'b1;
    end else if (t_go && link.acc_err) begin
      n.req  = 1'b0;
      n.dead = 1'b1;
      n.st   = ST_IDLE;
    end
    // a retry pulse leaves the request standing, so it goes out again

    unique case (q.st)
      ST_IDLE: begin
        // consume a pending wake; this also clears a wake written in the same cycle
        if (q.wake) n.wake = 1'b0;
        if (q.wake && q.run && !q.dead) begin
          n.st   = ST_FETCH;
          n.widx = 2'h0;
        end
      end
      ST_FETCH: if (done) begin
        n.widx = q.widx + 2'h1;
        if (q.widx == 2'h1) n.w1 = rdat;
        if (q.widx == 2'h2) n.w2 = rdat;
        if (q.widx == LAST_WORD) begin
          n.w3    = rdat;
          n.resid = rdat[15:0];
          if (rdat[W3_CMD_LSB +: 4] <= CMD_IN_LAST) begin
            n.maddr = q.w2;
            n.paddr = (rdat[W3_KEY_LSB +: 3] >= PORT_CHAN_REGS) ? q.w1 : '0;
            n.beats = {1'b0, nwords[16:2]};
          end else begin
            n.maddr = q.ptr + WORD_BYTES;
            n.paddr = q.w2;
            n.beats = 16'h0001;
          end
          unique case (rdat[W3_CMD_LSB +: 4])
            CMD_OUT_MORE, CMD_OUT_LAST, CMD_IN_MORE, CMD_IN_LAST:
              n.st = (nwords[16:2] == 15'h0) ? ST_STALL : ST_SRC;
            CMD_STORE_Q, CMD_LOAD_Q: n.st = ST_SRC;
            CMD_NO_OP: n.st = ST_STALL;
            CMD_STOP:  n.st = ST_IDLE;
            default: begin
              n.dead = 1'b1;
              n.st   = ST_IDLE;
            end
          endcase
        end
      end
      ST_SRC: if (done) begin
        n.data = rdat;
        n.st   = ST_DST;
      end
      ST_DST: if (done) begin
        n.maddr = q.maddr + WORD_BYTES;
        if (key >= PORT_CHAN_REGS) n.paddr = q.paddr + WORD_BYTES;
        n.resid = (q.resid >= WORD_CNT) ? q.resid - WORD_CNT : '0;
        n.beats = q.beats - 16'h1;
        n.st    = (q.beats == 16'h1) ? ST_STALL : ST_SRC;
      end
      ST_STALL: begin
        // re-evaluated every cycle, so a status write releases it
        if (!decide(q.w3[W3_WT_LSB +: 2], cond(q.s, q.ssel))) n.st = ST_WBACK;
      end
      ST_WBACK: if (done) n.st = ST_NOTIFY;
      ST_NOTIFY: begin
        if (!q.wmode) n.irq = decide(q.w3[W3_INT_LSB +: 2], cond(q.s, q.nsel));
        if (!t_go || done) n.st = ST_NEXT;
      end
      ST_NEXT: begin
        n.st   = ST_FETCH;
        n.widx = 2'h0;
        if ((opc <= CMD_IN_LAST || opc == CMD_NO_OP)
            && decide(q.w3[W3_BR_LSB +: 2], cond(q.s, q.jsel))) begin
          n.ptr = q.w1;
        end else begin
          n.ptr = q.ptr + DESC_BYTES;
        end
      end
    endcase

    // clearing run terminates processing, retries included
    if (!q.run && q.st != ST_IDLE) begin
      n.st  = ST_IDLE;
      n.req = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata          = q.prdata;
  assign pready          = penable;
  assign pslverr         = psel && penable && !hit;
  assign link.acc_req    = q.req;
  assign link.acc_we     = q.we;
  assign link.acc_space  = q.sp;
  assign link.acc_key    = q.key;
  assign link.acc_addr   = q.addr;
  assign link.acc_wdata  = q.wdata;
  assign link.notify_irq = q.irq;
endmodule : dma_channel_engine

//--- dma_link_monitor.sv
// Purpose: assertions on the engine to fabric link
// Assumes: one clock pclk, asynchronous active-low presetn
// Notes:   sees only the link signals, no bind
`timescale 1ns/100ps
module dma_link_monitor
  import dma_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link request
  input wire logic        acc_req,
  input wire logic        acc_we,
  input wire logic        acc_space,
  input wire logic [2:0]  acc_key,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  // link response
  input wire logic        acc_ack,
  input wire logic        acc_retry,
  input wire logic        acc_err,
  input wire logic [31:0] acc_rdata,
  input wire logic        notify_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // request holding and response pulses
  // ----------------------------------------------------------------
  req_hold_a: assert property (acc_req && !acc_ack && !acc_err |=> acc_req)
    else $error("link request dropped before its answer");
  req_stable_a: assert property (acc_req && !acc_ack && !acc_err
    |=> $stable({acc_we, acc_space, acc_key, acc_addr, acc_wdata}))
    else $error("link request changed while pending");
  retry_same_a: assert property (acc_retry |=> acc_req && $stable(acc_addr))
    else $error("retried access not repeated");
  resp_onehot_a: assert property ($onehot0({acc_ack, acc_retry, acc_err}))
    else $error("more than one link answer at once");
  resp_owner_a: assert property (acc_ack || acc_retry || acc_err |-> acc_req)
    else $error("link answer without request");
  ack_release_a: assert property (acc_ack |=> !acc_req && !acc_ack)
    else $error("request not released after ack");
  // ----------------------------------------------------------------
  // errors, alignment, notify
  // ----------------------------------------------------------------
  err_idle_a: assert property (acc_err |=> !acc_req [*3])
    else $error("engine kept running after bus error");
  word_align_a: assert property (acc_req && acc_space == SP_MEM
    |-> acc_addr[1:0] == 2'h0)
    else $error("memory access not word aligned");
  irq_pulse_a: assert property (notify_irq |=> !notify_irq)
    else $error("notify pulse longer than one cycle");
endmodule : dma_link_monitor

//--- tb_descriptor_dma_command_decoder.sv
// Purpose: both ends joined, memory and device responders in the bench
// Assumes: apb zero-wait, bus answers after random delay with retries
// Notes:   device read data is its address xor a fixed pattern
`timescale 1ns/100ps
module tb_descriptor_dma_command_decoder;
  import dma_pkg::*;
  localparam logic [31:0] GO = 32'h9000;
  localparam logic [31:0] PAT = 32'h5a5a_0000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, dat, pre0, pre1;
  logic        bus_req, bus_we, bus_done, bus_retry, bus_fault;
  logic [31:0] bus_addr, bus_wdata, bus_rdata;
  logic        dp_req, dp_we, dp_done, irq_line;
  logic [2:0]  dp_key;
  logic [31:0] dp_addr, dp_wdata, dp_rdata;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] dq [$];
  logic [31:0] dk [$];
  int          seed = 32'h869f;
  int          mismatches, tests_run, nirq, bcnt;
  bit          bhold, dhold;

  always #25 pclk = ~pclk;

  dma_link_if dma_link_if_i ();
  dma_channel_engine dma_channel_engine_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(dma_link_if_i));
  dma_fabric_port dma_fabric_port_i (.pclk(pclk), .presetn(presetn),
    .link(dma_link_if_i), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_done(bus_done),
    .bus_retry(bus_retry), .bus_fault(bus_fault), .bus_rdata(bus_rdata),
    .dp_req(dp_req), .dp_we(dp_we), .dp_key(dp_key), .dp_addr(dp_addr),
    .dp_wdata(dp_wdata), .dp_done(dp_done), .dp_rdata(dp_rdata),
    .irq_line(irq_line));
  dma_link_monitor dma_link_monitor_i (.pclk(pclk), .presetn(presetn),
    .acc_req(dma_link_if_i.acc_req), .acc_we(dma_link_if_i.acc_we),
    .acc_space(dma_link_if_i.acc_space), .acc_key(dma_link_if_i.acc_key),
    .acc_addr(dma_link_if_i.acc_addr), .acc_wdata(dma_link_if_i.acc_wdata),
    .acc_ack(dma_link_if_i.acc_ack), .acc_retry(dma_link_if_i.acc_retry),
    .acc_err(dma_link_if_i.acc_err), .acc_rdata(dma_link_if_i.acc_rdata),
    .notify_irq(dma_link_if_i.notify_irq));

  // ----------------------------------------------------------------
  // responders: memory with random delay and busy-retry, device port
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    bus_done <= 1'b0;
    bus_retry <= 1'b0;
    bus_fault <= 1'b0;
    dp_done <= 1'b0;
    if (irq_line === 1'b1) nirq <= nirq + 1;
    if (bhold) bhold <= 1'b0;
    else if (bus_req && bcnt > 0) bcnt <= bcnt - 1;
    else if (bus_req) begin
      bhold <= 1'b1;
      bcnt <= $random(seed) & 3;
      if (bus_addr >= 32'hf000) bus_fault <= 1'b1;
      else if ($random(seed) % 3 == 0) bus_retry <= 1'b1;
      else begin
        bus_done <= 1'b1;
        bus_rdata <= mem.exists(bus_addr) ? mem[bus_addr] : ~bus_addr;
        if (bus_we) mem[bus_addr] = bus_wdata;
      end
    end
    if (dhold) dhold <= 1'b0;
    else if (dp_req) begin
      dhold <= 1'b1;
      dp_done <= 1'b1;
      dp_rdata <= dp_addr ^ PAT;
      if (dp_we) dq.push_back(dp_wdata);
      if (dp_we) dk.push_back({dp_key, dp_addr[28:0]});
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    if (k >= 20) finish_test;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task ck(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : ck

  // polls until the channel leaves active; bounded
  task automatic run_wait;
    int k;
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (rd[STAT_ACTIVE] !== 1'b0 && k < 1000);
    if (k >= 1000) mismatches++;
    if (k >= 1000) finish_test;
  endtask : run_wait

  function automatic logic [31:0] cmd(input logic [3:0] op,
    input logic [2:0] key, input logic [1:0] i, b, input logic [15:0] n);
    return {op, 1'b0, key, 2'h0, i, b, 2'h0, n};
  endfunction : cmd

  // word0 preset to ones so a missing writeback shows
  task desc(input logic [31:0] a, c3, w1, w2);
    mem[a] = 32'hffff_ffff;
    mem[a + 32'h4] = w1;
    mem[a + 32'h8] = w2;
    mem[a + 32'hc] = c3;
  endtask : desc

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {bus_done, bus_retry, bus_fault, bus_rdata} = '0;
    {dp_done, dp_rdata, bhold, dhold, bcnt, nirq} = '0;
    {mismatches, tests_run} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    ck(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    ck({31'h0, err}, 32'h1);
    dat = $random(seed);
    pre0 = $random(seed);
    pre1 = $random(seed);
    mem[32'h500] = pre0;
    mem[32'h504] = pre1;
    desc(32'h100, cmd(CMD_STORE_Q, PORT_SYSTEM, CTL_ALWAYS, CTL_NEVER,
         16'h4), dat, 32'h400);
    desc(32'h110, cmd(CMD_OUT_LAST, PORT_DATA_STREAM, CTL_NEVER,
         CTL_ALWAYS, 16'h8), 32'h180, 32'h500);
    desc(32'h180, cmd(CMD_IN_LAST, PORT_DEVICE, CTL_NEVER, CTL_NEVER,
         16'h8), 32'h40, 32'h600);
    desc(32'h190, cmd(CMD_NO_OP, 3'h0, CTL_NEVER, CTL_SET, 16'h0),
         32'h1c0, 32'h0);
    desc(32'h1c0, cmd(CMD_STOP, 3'h0, CTL_NEVER, CTL_NEVER, 16'h0),
         32'h0, 32'h0);
    apb(1'b1, REG_PTR, 32'h100);
    apb(1'b1, REG_CTRL, GO);
    run_wait;
    ck(mem[32'h400], dat);
    ck(32'(dq.size()), 32'h2);
    ck(dq[0], pre0);
    ck(dq[1], pre1);
    ck(dk[0], 32'h0);
    ck(mem[32'h600], 32'h40 ^ PAT);
    ck(mem[32'h604], 32'h44 ^ PAT);
    ck({16'h0, mem[32'h110][15:0]}, 32'h0);
    ck({16'h0, mem[32'h180][15:0]}, 32'h0);
    ck(nirq, 32'h1);
    apb(1'b0, REG_PTR, 32'h0);
    ck(rd, 32'h1c0);
    // bus fault on fetch, restart refused until run toggles
    apb(1'b1, REG_PTR, 32'hf000);
    apb(1'b1, REG_CTRL, GO);
    run_wait;
    ck(32'(rd[STAT_DEAD]), 32'h1);
    apb(1'b1, REG_CTRL, GO);
    apb(1'b0, REG_STATUS, 32'h0);
    ck(32'(rd[STAT_DEAD]), 32'h1);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_PTR, 32'h1c0);
    apb(1'b1, REG_CTRL, GO);
    run_wait;
    ck(32'(rd[STAT_DEAD]), 32'h0);
    ck(32'(rd[STAT_RUN]), 32'h1);
    apb(1'b0, REG_PTR, 32'h0);
    ck(rd, 32'h1c0);
    // notify by write, quadlet load from the channel's own registers
    desc(32'h200, cmd(CMD_LOAD_Q, PORT_CHAN_REGS, CTL_ALWAYS, CTL_NEVER,
         16'h4), 32'h0, {24'h0, REG_WAKE_ADDR});
    desc(32'h210, cmd(CMD_STOP, 3'h0, CTL_NEVER, CTL_NEVER, 16'h0),
         32'h0, 32'h0);
    apb(1'b1, REG_WAKE_ADDR, 32'h700);
    apb(1'b1, REG_PTR, 32'h200);
    apb(1'b1, REG_CTRL, GO | 32'h2000);
    run_wait;
    ck(mem[32'h204], 32'h700);
    ck(mem[32'h700], 32'h200);
    ck(nirq, 32'h1);
    apb(1'b0, REG_PTR, 32'h0);
    ck(rd, 32'h210);
    finish_test;
  end
endmodule : tb_descriptor_dma_command_decoder
